// ==== phy_regs_pkg.sv ====
// Constants, field layouts and carrier types for the PHY interrupt and paging registers
package phy_regs_pkg;
	// Clock and timing
	localparam int CLK_NS = 20;
	localparam int SHORT_RESET_NS = 1300;
	localparam int SHORT_RESET_CYC = (SHORT_RESET_NS + CLK_NS - 1) / CLK_NS;
	localparam int SHORT_CNT_W = 7;

	// Ports
	localparam int NUM_PORTS = 2;
	localparam int PORT_IDX_W = 1;

	// Register indices; byte address is four times the index
	localparam logic [5:0] IDX_INT_CTRL = 6'h05;
	localparam logic [5:0] IDX_PAGE_PORT = 6'h07;
	localparam logic [5:0] IDX_PORT_LINE = 6'h08;
	localparam logic [5:0] IDX_PORT_SPEED = 6'h09;
	localparam logic [5:0] IDX_IRQ_MASK = 6'h10;
	localparam logic [5:0] IDX_LINK_CTRL = 6'h11;

	// Interrupt/control register fields (flags share layout with the mask)
	localparam int B_CFG_TO = 0;
	localparam int B_CPWR = 1;
	localparam int B_STATE_TO = 2;
	localparam int B_PORT_EV = 3;
	localparam int B_RESUME_EN = 4;
	localparam int B_SHORT_REQ = 5;
	localparam int B_ACCEL = 6;
	localparam int B_MSPEED = 7;

	// Page/port select fields
	localparam int F_PAGE_LSB = 5;
	localparam int F_PORT_LSB = 0;
	localparam logic [2:0] PAGE_PORT_STATUS = 3'h0;

	// Port line register fields
	localparam int F_ASTAT_LSB = 6;
	localparam int F_BSTAT_LSB = 4;
	localparam int B_CHILD = 3;
	localparam int B_CON = 2;
	localparam int B_BIAS = 1;
	localparam int B_DIS = 0;

	// Port speed register fields
	localparam int F_PEER_LSB = 5;
	localparam int B_EV_EN = 4;
	localparam int B_FAULT = 3;

	// Link control register fields
	localparam int B_LINK_CTRL = 0;
	localparam int B_LACTIVE = 1;
	localparam int B_CABLE_PWR = 2;

	// Reset values
	localparam logic [3:0] FLAGS_RST = 4'h2;
	localparam logic [3:0] MASK_RST = 4'h0;
	localparam logic LINK_CTRL_RST = 1'b1;

	// AXI responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Status of one cable port, from the port logic
	typedef struct packed {
		logic [1:0] a_line;
		logic [1:0] b_line;
		logic child_flag;
		logic con;
		logic bias;
		logic [2:0] peer_speed;
	} port_stat_t;

	// Sticky interrupt flags
	typedef struct packed {
		logic port_event_flag;
		logic state_timeout_flag;
		logic cable_power_flag;
		logic config_timeout_flag;
	} flags_t;

	typedef enum logic [1:0] {
		WR_COLLECT = 2'b01,
		WR_RESP = 2'b10
	} wr_state_t;

	typedef enum logic [1:0] {
		RD_IDLE = 2'b01,
		RD_DATA = 2'b10
	} rd_state_t;
endpackage : phy_regs_pkg

// ==== pin_sync3.sv ====
// Three-stage pin synchroniser that accepts a change once stages two and three agree
`timescale 1ns/10ps
module pin_sync3 #(
	parameter int W = 1
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] s1_r;
	logic [W-1:0] s2_r;
	logic [W-1:0] s3_r;

	// First stage feeds only the second, to contain metastability
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s1_r <= '0;
			s2_r <= '0;
			s3_r <= '0;
		end else begin
			s1_r <= d;
			s2_r <= s1_r;
			s3_r <= s2_r;
		end
	end

	// Output follows only a level seen on two successive samples
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			q <= '0;
		end else begin
			for (int i = 0; i < W; i++) begin
				if (s2_r[i] == s3_r[i]) begin
					q[i] <= s3_r[i];
				end
			end
		end
	end
endmodule : pin_sync3

// ==== phy_interrupt_and_port_paging_regs.sv ====
// Interrupt flags, link-on notification, reset requests and port paging registers
//
// Overview of operation
// - With resume interrupt enabled, any port starting resume sets the port event flag.
// - Resume enable plus inactive link plus timeout/power flag drives link-on output.
// - Writing short reset request starts 1.3 us short reset; any bus reset clears.
// - Arbitration timeout at tree-ID start sets config timeout flag; write one clears.
// - Only loop members raise config timeout; others get state timeout and reset.
// - Cable power sense falling edge sets cable power flag; reset value one.
// - State timeout sets its flag and requests a bus reset; write one clears.
// - Bias, connect, disable or fault change on enabled port sets port event flag.
// - Port event flag with inactive link drives link-on regardless of resume enable.
// - Accelerated arbitration enable drives ack-acceleration and fly-by; reset clears.
// - Multispeed concatenation enable lets mixed-speed concatenation; reset clears.
// - Three-bit page index picks the page answering addresses 8 to 15.
// - Four-bit port index picks the port for per-port accesses, from zero.
// - Page zero maps port status for the chosen port; selects live in register 7.
// - Port status page reads zero when the chosen port is not implemented.
// - Link counts active only when power status and active control are both set.
// - Per-port event enable lets that port's events set the flag; reset clears.
//
// Design decision made here: register access over AXI4-Lite.
`timescale 1ns/10ps
module phy_interrupt_and_port_paging_regs (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic cable_power_sense,
	input wire logic link_power_status,
	input wire logic arb_timeout,
	input wire logic tree_id_start,
	input wire logic state_timeout,
	input wire logic resume_start,
	input wire logic bus_reset_seen,
	input wire logic reset_opportunity,
	input wire phy_regs_pkg::port_stat_t [phy_regs_pkg::NUM_PORTS-1:0] port_status,
	input wire logic [phy_regs_pkg::NUM_PORTS-1:0] port_fault_set,
	output logic link_on_output,
	output logic short_reset_drive,
	output logic long_reset_request,
	output logic accel_arb_en,
	output logic multispeed_concat_en,
	output logic [phy_regs_pkg::NUM_PORTS-1:0] port_disable,
	output logic irq
);
	import phy_regs_pkg::*;

	// True for every register index this block answers
	function automatic logic reg_mapped(input logic [5:0] idx);
		reg_mapped = (idx == IDX_INT_CTRL) || (idx == IDX_PAGE_PORT) ||
			(idx == IDX_PORT_LINE) || (idx == IDX_PORT_SPEED) ||
			(idx == IDX_IRQ_MASK) || (idx == IDX_LINK_CTRL);
	endfunction : reg_mapped

	flags_t flags_r;
	logic [3:0] mask_r;
	logic resume_en_r;
	logic short_req_r;
	logic accel_r;
	logic mspeed_r;
	logic [2:0] page_r;
	logic [3:0] port_sel_r;
	logic link_ctrl_r;
	logic [NUM_PORTS-1:0] dis_r;
	logic [NUM_PORTS-1:0] ev_en_r;
	logic [NUM_PORTS-1:0] fault_r;
	logic [3:0] prev_r [NUM_PORTS];
	logic [SHORT_CNT_W-1:0] short_cnt_r;
	logic cable_pwr_prev_r;
	logic cable_pwr_s;
	logic link_pwr_s;
	wr_state_t wr_state_r;
	rd_state_t rd_state_r;
	logic aw_got_r;
	logic w_got_r;
	logic [5:0] aw_idx_r;
	logic [7:0] wbyte_r;
	logic wlane_r;

	// Pins from outside the clock domain
	pin_sync3 #(.W(2)) u_sync (
		.aclk(aclk),
		.aresetn(aresetn),
		.d({cable_power_sense, link_power_status}),
		.q({cable_pwr_s, link_pwr_s})
	);

	logic link_active;
	logic port_ok;
	logic [PORT_IDX_W-1:0] pidx;
	logic wr_fire;
	logic wr_ok;
	logic [NUM_PORTS-1:0] port_ev;
	logic cfg_to_set;
	logic cpwr_set;
	logic pev_set;

	// Link activity and page/port decode
	assign link_active = link_pwr_s & link_ctrl_r;
	assign port_ok = (page_r == PAGE_PORT_STATUS) && (port_sel_r < NUM_PORTS);
	assign pidx = port_sel_r[PORT_IDX_W-1:0];
	assign wr_fire = (wr_state_r == WR_COLLECT) && aw_got_r && w_got_r;
	assign wr_ok = wr_fire && wlane_r;

	// Port events: watched bits differ from last cycle on an enabled port
	always_comb begin
		for (int i = 0; i < NUM_PORTS; i++) begin
			port_ev[i] = ev_en_r[i] &&
				({port_status[i].bias, port_status[i].con, dis_r[i], fault_r[i]} != prev_r[i]);
		end
	end

	// Flag set conditions
	assign cfg_to_set = arb_timeout && tree_id_start;
	assign cpwr_set = cable_pwr_prev_r && !cable_pwr_s;
	assign pev_set = (|port_ev) || (resume_en_r && resume_start);

	// AXI write channel: address and data taken in either order
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wr_state_r <= WR_COLLECT;
			aw_got_r <= 1'b0;
			w_got_r <= 1'b0;
			aw_idx_r <= 6'h00;
			wbyte_r <= 8'h00;
			wlane_r <= 1'b0;
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
		end else begin
			case (wr_state_r)
				WR_COLLECT: begin
					if (s_axi_awvalid && s_axi_awready) begin
						aw_got_r <= 1'b1;
						aw_idx_r <= s_axi_awaddr[7:2];
						s_axi_awready <= 1'b0;
					end
					if (s_axi_wvalid && s_axi_wready) begin
						w_got_r <= 1'b1;
						wbyte_r <= s_axi_wdata[7:0];
						wlane_r <= s_axi_wstrb[0];
						s_axi_wready <= 1'b0;
					end
					if (wr_fire) begin
						s_axi_bvalid <= 1'b1;
						s_axi_bresp <= reg_mapped(aw_idx_r) ? RESP_OKAY : RESP_SLVERR;
						wr_state_r <= WR_RESP;
					end
				end
				WR_RESP: begin
					if (s_axi_bready) begin
						s_axi_bvalid <= 1'b0;
						aw_got_r <= 1'b0;
						w_got_r <= 1'b0;
						s_axi_awready <= 1'b1;
						s_axi_wready <= 1'b1;
						wr_state_r <= WR_COLLECT;
					end
				end
				default: begin
					wr_state_r <= WR_COLLECT;
				end
			endcase
		end
	end

	// Sticky flags; hardware set outranks a same-cycle write-one clear
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			flags_r <= flags_t'(FLAGS_RST);
		end else begin
			if (wr_ok && aw_idx_r == IDX_INT_CTRL) begin
				// A zero bit leaves its flag alone
				if (wbyte_r[B_CFG_TO]) flags_r.config_timeout_flag <= 1'b0;
				if (wbyte_r[B_CPWR]) flags_r.cable_power_flag <= 1'b0;
				if (wbyte_r[B_STATE_TO]) flags_r.state_timeout_flag <= 1'b0;
				if (wbyte_r[B_PORT_EV]) flags_r.port_event_flag <= 1'b0;
			end
			if (cfg_to_set) flags_r.config_timeout_flag <= 1'b1;
			if (cpwr_set) flags_r.cable_power_flag <= 1'b1;
			if (state_timeout) flags_r.state_timeout_flag <= 1'b1;
			if (pev_set) flags_r.port_event_flag <= 1'b1;
		end
	end

	// Control bits; besides writes, only hardware reset touches the enables
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			resume_en_r <= 1'b0;
			accel_r <= 1'b0;
			mspeed_r <= 1'b0;
			mask_r <= MASK_RST;
			link_ctrl_r <= LINK_CTRL_RST;
		end else if (wr_ok) begin
			if (aw_idx_r == IDX_INT_CTRL) begin
				resume_en_r <= wbyte_r[B_RESUME_EN];
				accel_r <= wbyte_r[B_ACCEL];
				mspeed_r <= wbyte_r[B_MSPEED];
			end
			if (aw_idx_r == IDX_IRQ_MASK) begin
				mask_r <= wbyte_r[3:0];
			end
			if (aw_idx_r == IDX_LINK_CTRL) begin
				link_ctrl_r <= wbyte_r[B_LINK_CTRL];
			end
		end
	end

	// Short reset request: held until any bus reset is seen
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			short_req_r <= 1'b0;
		end else if (bus_reset_seen) begin
			short_req_r <= 1'b0;
		end else if (wr_ok && aw_idx_r == IDX_INT_CTRL && wbyte_r[B_SHORT_REQ]) begin
			short_req_r <= 1'b1;
		end
	end

	// Short reset drive lasts the fixed 1.3 us count once an opportunity comes
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			short_cnt_r <= '0;
			short_reset_drive <= 1'b0;
		end else if (short_cnt_r != '0) begin
			short_cnt_r <= short_cnt_r - SHORT_CNT_W'(1);
			short_reset_drive <= (short_cnt_r != SHORT_CNT_W'(1));
		end else if (short_req_r && reset_opportunity && !short_reset_drive) begin
			short_cnt_r <= SHORT_CNT_W'(SHORT_RESET_CYC);
			short_reset_drive <= 1'b1;
		end else begin
			short_reset_drive <= 1'b0;
		end
	end

	// Page and port selection, unaffected by bus reset
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			page_r <= 3'h0;
			port_sel_r <= 4'h0;
		end else if (wr_ok && aw_idx_r == IDX_PAGE_PORT) begin
			page_r <= wbyte_r[F_PAGE_LSB +: 3];
			port_sel_r <= wbyte_r[F_PORT_LSB +: 4];
		end
	end

	// Per-port disable, event enable and fault; writes to missing ports drop
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			dis_r <= '0;
			ev_en_r <= '0;
			fault_r <= '0;
		end else begin
			if (wr_ok && port_ok && aw_idx_r == IDX_PORT_LINE) begin
				dis_r[pidx] <= wbyte_r[B_DIS];
			end
			if (wr_ok && port_ok && aw_idx_r == IDX_PORT_SPEED) begin
				ev_en_r[pidx] <= wbyte_r[B_EV_EN];
				if (wbyte_r[B_FAULT]) fault_r[pidx] <= 1'b0;
			end
			for (int i = 0; i < NUM_PORTS; i++) begin
				if (port_fault_set[i]) fault_r[i] <= 1'b1;
			end
		end
	end

	// Last-seen port bits for change detection
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			for (int i = 0; i < NUM_PORTS; i++) prev_r[i] <= 4'h0;
			cable_pwr_prev_r <= 1'b0;
		end else begin
			for (int i = 0; i < NUM_PORTS; i++) begin
				prev_r[i] <= {port_status[i].bias, port_status[i].con, dis_r[i], fault_r[i]};
			end
			cable_pwr_prev_r <= cable_pwr_s;
		end
	end

	// Link-on, interrupt and feature outputs, all registered
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			link_on_output <= 1'b0;
			irq <= 1'b0;
			long_reset_request <= 1'b0;
			accel_arb_en <= 1'b0;
			multispeed_concat_en <= 1'b0;
			port_disable <= '0;
		end else begin
			link_on_output <= !link_active && (flags_r.port_event_flag ||
				(resume_en_r && (flags_r.config_timeout_flag || flags_r.cable_power_flag ||
				flags_r.state_timeout_flag)));
			irq <= |(4'(flags_r) & mask_r);
			long_reset_request <= state_timeout;
			accel_arb_en <= accel_r;
			multispeed_concat_en <= mspeed_r;
			port_disable <= dis_r;
		end
	end

	// Read data for the addressed register
	logic [7:0] rbyte;
	always_comb begin
		rbyte = 8'h00;
		case (s_axi_araddr[7:2])
			IDX_INT_CTRL: begin
				rbyte = {mspeed_r, accel_r, short_req_r, resume_en_r, 4'(flags_r)};
			end
			IDX_PAGE_PORT: begin
				rbyte = {page_r, 1'b0, port_sel_r};
			end
			IDX_PORT_LINE: begin
				if (port_ok) begin
					rbyte = {port_status[pidx].a_line, port_status[pidx].b_line,
						port_status[pidx].child_flag, port_status[pidx].con,
						port_status[pidx].bias, dis_r[pidx]};
				end
			end
			IDX_PORT_SPEED: begin
				if (port_ok) begin
					rbyte = {port_status[pidx].peer_speed, ev_en_r[pidx], fault_r[pidx], 3'h0};
				end
			end
			IDX_IRQ_MASK: begin
				rbyte = {4'h0, mask_r};
			end
			IDX_LINK_CTRL: begin
				rbyte = {5'h00, cable_pwr_s, link_active, link_ctrl_r};
			end
			default: begin
				rbyte = 8'h00;
			end
		endcase
	end

	// AXI read channel: data one cycle after the address is taken
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rd_state_r <= RD_IDLE;
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= RESP_OKAY;
		end else begin
			case (rd_state_r)
				RD_IDLE: begin
					if (s_axi_arvalid) begin
						s_axi_arready <= 1'b0;
						s_axi_rvalid <= 1'b1;
						s_axi_rdata <= {24'h00_0000, rbyte};
						s_axi_rresp <= reg_mapped(s_axi_araddr[7:2]) ? RESP_OKAY : RESP_SLVERR;
						rd_state_r <= RD_DATA;
					end
				end
				RD_DATA: begin
					if (s_axi_rready) begin
						s_axi_rvalid <= 1'b0;
						s_axi_arready <= 1'b1;
						rd_state_r <= RD_IDLE;
					end
				end
				default: begin
					rd_state_r <= RD_IDLE;
				end
			endcase
		end
	end
endmodule : phy_interrupt_and_port_paging_regs

// ==== phy_regs_monitor.sv ====
// Checker for bus answers, bus reset pulses and control enables
`timescale 1ns/10ps
module phy_regs_monitor (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic s_axi_bvalid,
	input wire logic state_timeout,
	input wire logic reset_opportunity,
	input wire logic short_reset_drive,
	input wire logic long_reset_request,
	input wire logic accel_arb_en,
	input wire logic multispeed_concat_en
);
	import phy_regs_pkg::*;
	int run_cnt;
	default clocking @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	// High cycles of the short reset so far; a counter avoids a huge repetition
	always_ff @(posedge aclk) begin
		if (!aresetn || !short_reset_drive) begin
			run_cnt <= 0;
		end else begin
			run_cnt <= run_cnt + 1;
		end
	end
	chk_long_follows: assert property (state_timeout |=> long_reset_request)
		else $error("long reset missing after state timeout");
	chk_long_cause: assert property (long_reset_request |-> $past(state_timeout))
		else $error("long reset without state timeout");
	chk_short_start: assert property ($rose(short_reset_drive) |-> $past(reset_opportunity))
		else $error("short reset began without opportunity");
	chk_short_length: assert property ($fell(short_reset_drive) |-> run_cnt == SHORT_RESET_CYC)
		else $error("short reset length wrong");
	chk_ctrl_by_write: assert property
		($changed({accel_arb_en, multispeed_concat_en}) |-> $past(s_axi_bvalid))
		else $error("control enable changed without a write");
	chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read not answered");
	chk_read_release: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
		else $error("read answer not released");
	chk_read_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
		else $error("read data upper bits set");
endmodule : phy_regs_monitor

bind phy_interrupt_and_port_paging_regs phy_regs_monitor u_mon (
	.aclk, .aresetn, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
	.s_axi_rready, .s_axi_bvalid, .state_timeout, .reset_opportunity, .short_reset_drive,
	.long_reset_request, .accel_arb_en, .multispeed_concat_en
);

// ==== link_partner.sv ====
// Link layer controller model that powers up when notified by link-on
`timescale 1ns/10ps
module link_partner #(
	parameter int WAKE = 20
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic link_on,
	output logic link_pwr
);
	int cnt = 0;
	initial link_pwr = 1'b0;
	// Wake-up delay; a larger WAKE models a slow controller
	always @(posedge aclk) begin
		if (!aresetn) begin
			cnt <= 0;
			link_pwr <= 1'b0;
		end else if (link_on && !link_pwr) begin
			cnt <= cnt + 1;
			if (cnt == WAKE) link_pwr <= 1'b1;
		end
	end
endmodule : link_partner

// ==== test_phy_interrupt_and_port_paging_regs.sv ====
// Testbench for the interrupt flag and port paging register block
`timescale 1ns/10ps
module test_phy_interrupt_and_port_paging_regs;
	import phy_regs_pkg::*;
	localparam logic [7:0] A_CTRL = {IDX_INT_CTRL, 2'b00};
	localparam logic [7:0] A_SEL = {IDX_PAGE_PORT, 2'b00};
	localparam logic [7:0] A_LINE = {IDX_PORT_LINE, 2'b00};
	localparam logic [7:0] A_SPD = {IDX_PORT_SPEED, 2'b00};
	localparam logic [7:0] A_MASK = {IDX_IRQ_MASK, 2'b00};
	localparam logic [7:0] A_LINK = {IDX_LINK_CTRL, 2'b00};
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp, port_disable;
	logic [31:0] s_axi_rdata;
	logic cable_power_sense = 1'b1, tree_id_start = 1'b0, reset_opportunity = 1'b0;
	logic link_power_status, arb_timeout, state_timeout, resume_start, bus_reset_seen;
	logic [3:0] ev = 4'h0;
	port_stat_t [NUM_PORTS-1:0] pst = {10'h300, 10'h1B2};
	logic [NUM_PORTS-1:0] port_fault_set = '0;
	logic link_on_output, short_reset_drive, long_reset_request;
	logic accel_arb_en, multispeed_concat_en, irq;
	int compares = 0, miscompares = 0, cycles = 0, n = 0;

	// Single-cycle event pulses share one vector
	assign {arb_timeout, state_timeout, resume_start, bus_reset_seen} = ev;

	phy_interrupt_and_port_paging_regs DUT (
		.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .cable_power_sense, .link_power_status,
		.arb_timeout, .tree_id_start, .state_timeout, .resume_start, .bus_reset_seen,
		.reset_opportunity, .port_status(pst), .port_fault_set, .link_on_output,
		.short_reset_drive, .long_reset_request, .accel_arb_en, .multispeed_concat_en,
		.port_disable, .irq
	);

	link_partner #(.WAKE(20)) u_link (
		.aclk, .aresetn, .link_on(link_on_output), .link_pwr(link_power_status)
	);

	always #10 aclk = ~aclk;

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			miscompares++;
			$display("FAIL at %0t: seen %0h expected %0h", $time, seen, exp);
		end
	endtask : check

	task automatic finish_test();
		$display("Compares %0d, miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : finish_test

	// Address and data offered together; each released once taken
	task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er = RESP_OKAY);
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h0, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (s_axi_awvalid || s_axi_wvalid);
		while (!s_axi_bvalid) @(posedge aclk);
		s_axi_bready <= 1'b0;
		check(s_axi_bresp, er);
		// One edge between calls so no signal is assigned twice in a step
		@(posedge aclk);
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [7:0] exp, input logic [1:0] er = RESP_OKAY);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge aclk); while (!s_axi_arready);
		s_axi_arvalid <= 1'b0;
		do @(posedge aclk); while (!s_axi_rvalid);
		s_axi_rready <= 1'b0;
		check(s_axi_rdata, {24'h0, exp});
		check(s_axi_rresp, er);
		@(posedge aclk);
	endtask : rd

	task automatic pulse(input logic [3:0] m);
		ev <= m;
		@(posedge aclk);
		ev <= 4'h0;
		repeat (3) @(posedge aclk);
	endtask : pulse

	// Hang guard, well above the expected run length
	always @(posedge aclk) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			miscompares++;
			finish_test();
		end
	end

	initial begin
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (6) @(posedge aclk);
		rd(A_CTRL, 8'h02);
		rd(A_SEL, 8'h00);
		rd(A_MASK, 8'h00);
		rd(A_LINK, 8'h05);
		rd(8'h00, 8'h00, RESP_SLVERR);
		wr(8'h0C, 8'hFF, RESP_SLVERR);
		// Zero writes and disabled strobes leave flags alone
		wr(A_CTRL, 8'h00);
		rd(A_CTRL, 8'h02);
		s_axi_wstrb <= 4'h0;
		wr(A_CTRL, 8'h02);
		s_axi_wstrb <= 4'hF;
		rd(A_CTRL, 8'h02);
		wr(A_CTRL, 8'h02);
		rd(A_CTRL, 8'h00);
		// Acceleration only with a compliant controller, which this model is
		wr(A_CTRL, 8'hE0);
		repeat (5) @(posedge aclk);
		check(short_reset_drive, 1'b0);
		check({accel_arb_en, multispeed_concat_en}, 2'h3);
		reset_opportunity <= 1'b1;
		while (!short_reset_drive) @(posedge aclk);
		reset_opportunity <= 1'b0;
		while (short_reset_drive) begin
			n++;
			@(posedge aclk);
		end
		check(n, SHORT_RESET_CYC);
		pulse(4'h1);
		rd(A_CTRL, 8'hC0);
		// Event flags and their qualifiers
		wr(A_CTRL, 8'h00);
		pulse(4'h8);
		rd(A_CTRL, 8'h00);
		tree_id_start <= 1'b1;
		pulse(4'h8);
		tree_id_start <= 1'b0;
		rd(A_CTRL, 8'h01);
		pulse(4'h2);
		rd(A_CTRL, 8'h01);
		check(link_on_output, 1'b0);
		pulse(4'h4);
		rd(A_CTRL, 8'h05);
		cable_power_sense <= 1'b0;
		repeat (8) @(posedge aclk);
		rd(A_CTRL, 8'h07);
		check(irq, 1'b0);
		wr(A_MASK, 8'h04);
		repeat (2) @(posedge aclk);
		check(irq, 1'b1);
		wr(A_CTRL, 8'h10);
		repeat (3) @(posedge aclk);
		check(link_on_output, 1'b1);
		repeat (40) @(posedge aclk);
		check({link_power_status, link_on_output}, 2'h2);
		pulse(4'h2);
		rd(A_CTRL, 8'h1F);
		wr(A_CTRL, 8'h1F);
		rd(A_CTRL, 8'h10);
		check(irq, 1'b0);
		// Port events with the link held inactive by software
		wr(A_CTRL, 8'h00);
		wr(A_LINK, 8'h00);
		wr(A_SEL, 8'h00);
		wr(A_SPD, 8'h10);
		rd(A_SPD, 8'h50);
		pst[1].bias <= 1'b1;
		repeat (3) @(posedge aclk);
		rd(A_CTRL, 8'h00);
		check(link_on_output, 1'b0);
		pst[0].bias <= 1'b1;
		repeat (3) @(posedge aclk);
		rd(A_CTRL, 8'h08);
		check(link_on_output, 1'b1);
		wr(A_LINK, 8'h01);
		repeat (8) @(posedge aclk);
		check(link_on_output, 1'b0);
		// Page and port steering
		rd(A_LINE, 8'h6E);
		wr(A_LINE, 8'h01);
		repeat (2) @(posedge aclk);
		check(port_disable, 2'h1);
		wr(A_SEL, 8'h01);
		rd(A_LINE, 8'hC2);
		port_fault_set <= 2'h2;
		@(posedge aclk);
		port_fault_set <= 2'h0;
		rd(A_SPD, 8'h08);
		wr(A_SEL, 8'h02);
		rd(A_SPD, 8'h00);
		wr(A_SEL, 8'h20);
		rd(A_LINE, 8'h00);
		rd(A_SEL, 8'h20);
		finish_test();
	end
endmodule : test_phy_interrupt_and_port_paging_regs
